// ===== rtl/upconv_scale_ctrl.sv
// Scale and configuration timing control in the up-converter output path.
// Assumes sequencer, control and sample stream all run on clk_i (100 MHz).
//
// Summary of operation
// [R01] Action-table change waits pending for next marker
// [R02] Placement resolution eight, two, one, one pairs
// [R03] Amplitude-table changes apply at once, unaligned
// [R04] Detect converter overrange and report sticky clipping
// [R05] Table scale accepted only from zero to one
// [R06] Each segment entry may carry its own scale
// [R07] Global scale accepted from zero to 2.828
// [R08] Multiplier equals global times current table scale
// [R09] Coarse delay live in direct, restart in up-conversion
// [R10] Controller keeps markers out of first 240 pairs
// [R11] Overrange samples saturate to nearest limit
`timescale 1ns/1ps
module upconv_scale_ctrl
  import upconv_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Operating mode and run control
  input wire logic digital_upconversion_mode_i,
  input wire interp_mode_e interp_mode_i,
  input wire logic run_i,
  // Global scale and coarse delay from control software
  input wire logic global_scale_we_i,
  input wire logic [15:0] global_scale_i,
  input wire logic coarse_delay_we_i,
  input wire logic [7:0] coarse_delay_i,
  // Amplitude-table entry
  input wire logic amp_table_valid_i,
  input wire logic [15:0] amp_table_scale_i,
  // Action-table entry
  input wire logic action_valid_i,
  input wire logic [15:0] action_scale_i,
  // Status clear from software
  input wire logic clip_clear_i,
  input wire logic reject_clear_i,
  // Processed sample stream in
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire iq_pair_s in_pair_i,
  input wire logic in_marker_i,
  // Converter sample stream out
  output logic dac_valid_o,
  input wire logic dac_ready_i,
  output iq_pair_s dac_pair_o,
  // Status and settings
  output logic [15:0] amp_mult_o,
  output logic [7:0] coarse_delay_o,
  output logic clip_status_o,
  output logic reject_status_o,
  output logic action_pending_o
);

  logic [15:0] global_scale, next_global_scale;
  logic [15:0] table_scale, next_table_scale;
  logic [15:0] pend_scale, next_pend_scale;
  logic pending, next_pending;
  logic marker_armed, next_marker_armed;
  logic [2:0] pair_phase, next_pair_phase;
  logic [7:0] delay_req, next_delay_req;
  logic [7:0] next_coarse_delay;
  logic [15:0] next_amp_mult;
  logic next_clip, next_reject;
  logic run_q;
  logic [3:0] resolution;
  logic beat;
  logic [31:0] amp_prod;
  logic clip_i_hit, clip_q_hit;
  iq_pair_s scaled;
  logic fifo_ready;
  iq_pair_s fifo_out;

  assign beat = in_valid_i && fifo_ready;
  assign in_ready_o = fifo_ready;
  assign dac_pair_o = fifo_out;

  always_comb begin
    unique case (interp_mode_i)
      interpolate_by_three: resolution = RES_BY_THREE; // R02
      interpolate_by_twelve: resolution = RES_BY_TWELVE; // R02
      interpolate_by_twenty_four: resolution = RES_BY_TWENTY_FOUR; // R02
      interpolate_by_forty_eight: resolution = RES_BY_FORTY_EIGHT; // R02
    endcase
  end

  // Multiply Q1.15 table scale by Q2.14 global scale, keep Q2.14
  assign amp_prod = global_scale * table_scale; // R08

  // Scale one component by the multiplier, saturate and flag overrange
  function automatic logic signed [15:0] scale_sat(input logic signed [15:0] s,
                                                   input logic [15:0] m,
                                                   output logic hit);
    logic signed [32:0] p;
    logic signed [18:0] r;
    p = s * $signed({1'b0, m});
    r = p[32:SAMPLE_PROD_LSB];
    hit = 1'b0;
    scale_sat = r[15:0];
    if (r > 19'(SAMPLE_MAX)) begin
      hit = 1'b1; // R04
      scale_sat = SAMPLE_MAX; // R11
    end else if (r < 19'(SAMPLE_MIN)) begin
      hit = 1'b1; // R04
      scale_sat = SAMPLE_MIN; // R11
    end
  endfunction

  always_comb begin
    scaled.i = scale_sat(in_pair_i.i, amp_mult_o, clip_i_hit);
    scaled.q = scale_sat(in_pair_i.q, amp_mult_o, clip_q_hit);
  end

  always_comb begin
    next_global_scale = global_scale;
    next_table_scale = table_scale;
    next_pend_scale = pend_scale;
    next_pending = pending;
    next_marker_armed = marker_armed;
    next_pair_phase = pair_phase;
    next_delay_req = delay_req;
    next_coarse_delay = coarse_delay_o;
    next_reject = reject_status_o && !reject_clear_i;
    next_clip = clip_status_o && !clip_clear_i;

    if (global_scale_we_i) begin
      if (global_scale_i <= GLOBAL_SCALE_MAX) begin
        next_global_scale = global_scale_i; // R07
      end else begin
        next_reject = 1'b1; // R07
      end
    end

    // Marker-aligned change: taken on a marker, placed on a resolution boundary
    if (beat) begin
      // Compare in four bits so a resolution of eight still counts through all eight phases
      next_pair_phase = ({1'b0, pair_phase} + 4'h1 >= resolution) ? 3'h0 : pair_phase + 3'h1; // R02
      if (pending && (in_marker_i || marker_armed)) begin
        if (pair_phase == 3'h0) begin
          next_table_scale = pend_scale; // R01 R06
          next_pending = 1'b0; // R01
          next_marker_armed = 1'b0;
        end else begin
          next_marker_armed = 1'b1; // R02
        end
      end
    end

    // Unaligned amplitude-table update takes effect immediately
    if (amp_table_valid_i) begin
      if (amp_table_scale_i <= TABLE_SCALE_ONE) begin
        next_table_scale = amp_table_scale_i; // R03 R06
      end else begin
        next_reject = 1'b1; // R05
      end
    end

    // A new action entry replaces one still waiting; relies on marker spacing
    if (action_valid_i) begin
      if (action_scale_i <= TABLE_SCALE_ONE) begin
        next_pend_scale = action_scale_i; // R05
        next_pending = 1'b1; // R01 R10
        next_marker_armed = 1'b0;
      end else begin
        next_reject = 1'b1; // R05
      end
    end

    // Coarse delay: live in direct mode, held to a restart in up-conversion
    if (coarse_delay_we_i) begin
      next_delay_req = coarse_delay_i;
      if (!digital_upconversion_mode_i) begin
        next_coarse_delay = coarse_delay_i; // R09
      end
    end
    if (digital_upconversion_mode_i && run_i && !run_q) begin
      next_coarse_delay = coarse_delay_we_i ? coarse_delay_i : delay_req; // R09
    end

    if (beat && (clip_i_hit || clip_q_hit)) begin
      next_clip = 1'b1; // R04
    end

    next_amp_mult = amp_prod[AMP_PROD_LSB+15:AMP_PROD_LSB]; // R08
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      global_scale <= RESET_GLOBAL_SCALE;
      table_scale <= RESET_TABLE_SCALE;
      pend_scale <= RESET_TABLE_SCALE;
      pending <= 1'b0;
      marker_armed <= 1'b0;
      pair_phase <= 3'h0;
      delay_req <= RESET_COARSE_DELAY;
      coarse_delay_o <= RESET_COARSE_DELAY;
      amp_mult_o <= RESET_AMP_MULT;
      clip_status_o <= 1'b0;
      reject_status_o <= 1'b0;
      action_pending_o <= 1'b0;
      run_q <= 1'b0;
    end else begin
      global_scale <= next_global_scale;
      table_scale <= next_table_scale;
      pend_scale <= next_pend_scale;
      pending <= next_pending;
      marker_armed <= next_marker_armed;
      pair_phase <= next_pair_phase;
      delay_req <= next_delay_req;
      coarse_delay_o <= next_coarse_delay;
      amp_mult_o <= next_amp_mult;
      clip_status_o <= next_clip;
      reject_status_o <= next_reject;
      action_pending_o <= next_pending;
      run_q <= run_i;
    end
  end

  sample_fifo #(
    .WIDTH(IQ_PAIR_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(in_valid_i),
    .in_ready_o(fifo_ready),
    .in_data_i(scaled),
    .out_valid_o(dac_valid_o),
    .out_ready_i(dac_ready_i),
    .out_data_o(fifo_out)
  );

endmodule

// ===== rtl/upconv_pkg.sv
// Constants and carrier types shared by the up-converter scale and configuration timing logic.
// Assumes one 100 MHz sample clock and fixed-point scale formats described below.
package upconv_pkg;

  // Table scale: unsigned Q1.15, 1.0 = 0x8000
  localparam logic [15:0] TABLE_SCALE_ONE = 16'h8000;
  // Global scale: unsigned Q2.14, 1.0 = 0x4000, 2.828 = 0xB4FE
  localparam logic [15:0] GLOBAL_SCALE_ONE = 16'h4000;
  localparam logic [15:0] GLOBAL_SCALE_MAX = 16'hB4FE;
  // Bit positions used to drop fraction bits after each product
  localparam int AMP_PROD_LSB = 15;
  localparam int SAMPLE_PROD_LSB = 14;
  // Signed converter limits
  localparam logic signed [15:0] SAMPLE_MAX = 16'sh7FFF;
  localparam logic signed [15:0] SAMPLE_MIN = -16'sh8000;
  // Marker-aligned placement resolution in IQ pairs
  localparam logic [3:0] RES_BY_THREE = 4'h8;
  localparam logic [3:0] RES_BY_TWELVE = 4'h2;
  localparam logic [3:0] RES_BY_TWENTY_FOUR = 4'h1;
  localparam logic [3:0] RES_BY_FORTY_EIGHT = 4'h1;
  // Shortest configuration segment the controller must supply, in IQ pairs
  localparam int MIN_CFG_SEGMENT_PAIRS = 240;
  // Output buffer
  localparam int FIFO_DEPTH = 4;
  // Values after reset
  localparam logic [15:0] RESET_TABLE_SCALE = TABLE_SCALE_ONE;
  localparam logic [15:0] RESET_GLOBAL_SCALE = GLOBAL_SCALE_ONE;
  localparam logic [15:0] RESET_AMP_MULT = GLOBAL_SCALE_ONE;
  localparam logic [7:0] RESET_COARSE_DELAY = 8'h00;

  typedef enum logic [1:0] {
    interpolate_by_three,
    interpolate_by_twelve,
    interpolate_by_twenty_four,
    interpolate_by_forty_eight
  } interp_mode_e;

  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } iq_pair_s;

  localparam int IQ_PAIR_BITS = $bits(iq_pair_s);

endpackage

// ===== rtl/sample_fifo.sv
// Small synchronous FIFO carrying scaled IQ pairs toward the converter.
// Assumes both sides on clk_i; ready and valid flags are registered.
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr, next_wr_ptr;
  logic [PTR_W-1:0] rd_ptr, next_rd_ptr;
  logic [PTR_W:0] count, next_count;
  logic push, pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready_o <= (next_count != DEPTH_CNT);
      out_valid_o <= (next_count != '0);
    end
  end

  // Storage has no reset; only written entries are ever presented
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule

// ===== test/upconv_scale_ctrl_sva.sv
// Port checker for upconv_scale_ctrl.
// Assumes one clock domain; bound to every instance.
`timescale 1ns/1ps
module upconv_scale_ctrl_sva (
  // Clock, reset, mode
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic digital_upconversion_mode_i,
  input wire logic run_i,
  // Requests
  input wire logic global_scale_we_i,
  input wire logic [15:0] global_scale_i,
  input wire logic coarse_delay_we_i,
  input wire logic [7:0] coarse_delay_i,
  input wire logic amp_table_valid_i,
  input wire logic [15:0] amp_table_scale_i,
  input wire logic action_valid_i,
  input wire logic [15:0] action_scale_i,
  input wire logic clip_clear_i,
  input wire logic in_valid_i,
  // Outputs
  input wire logic in_ready_o,
  input wire logic dac_valid_o,
  input wire logic [7:0] coarse_delay_o,
  input wire logic clip_status_o,
  input wire logic reject_status_o,
  input wire logic action_pending_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_grej; global_scale_we_i && global_scale_i > 16'hB4FE |=> reject_status_o; endproperty
  a_grej: assert property (p_grej) else $error("global scale not refused");
  property p_arej; amp_table_valid_i && amp_table_scale_i > 16'h8000 |=> reject_status_o; endproperty
  a_arej: assert property (p_arej) else $error("table scale not refused");
  property p_pend; action_valid_i && action_scale_i <= 16'h8000 |=> action_pending_o; endproperty
  a_pend: assert property (p_pend) else $error("action not pending");
  property p_wait; action_pending_o && !in_valid_i && !action_valid_i |=> action_pending_o; endproperty
  a_wait: assert property (p_wait) else $error("action applied without beat");
  property p_clip; clip_status_o && !clip_clear_i |=> clip_status_o; endproperty
  a_clip: assert property (p_clip) else $error("clip flag lost");
  property p_dlyu; digital_upconversion_mode_i && !$rose(run_i) |=> $stable(coarse_delay_o); endproperty
  a_dlyu: assert property (p_dlyu) else $error("delay moved while running");
  property p_dlyd; !digital_upconversion_mode_i && coarse_delay_we_i |=> coarse_delay_o == $past(coarse_delay_i); endproperty
  a_dlyd: assert property (p_dlyd) else $error("direct delay not taken");
  property p_fifo; in_valid_i && in_ready_o && !dac_valid_o |=> dac_valid_o; endproperty
  a_fifo: assert property (p_fifo) else $error("beat not forwarded");
  cover property (action_pending_o ##1 !action_pending_o);
  cover property ($rose(clip_status_o));
  cover property (!in_ready_o);
endmodule

bind upconv_scale_ctrl upconv_scale_ctrl_sva i_sva (.*);

// ===== test/dac_sink.sv
// Converter model: takes pairs while ready, stalls on request.
// Assumes the bench drives stall_i; taken pairs queue in got.
`timescale 1ns/1ps
module dac_sink
  import upconv_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Stream from the block
  input wire logic valid_i,
  output logic ready_o,
  input wire iq_pair_s pair_i,
  // Bench control
  input wire logic stall_i
);
  iq_pair_s got[$];
  initial ready_o = 1'b0;
  always @(negedge clk_i) ready_o <= !stall_i;
  always @(posedge clk_i) if (valid_i && ready_o) got.push_back(pair_i);
endmodule

// ===== test/tb_upconv_scale_ctrl.sv
// Bench for the scale and configuration timing block.
// Assumes the dac_sink model and the bound checker.
`timescale 1ns/1ps
module tb_upconv_scale_ctrl;
  import upconv_pkg::*;
  typedef struct {logic [15:0] g, t, m; logic [31:0] p, o; logic c;} row_s;
  logic clk_i = 1'b0, reset_n_i = 1'b0, digital_upconversion_mode_i = 1'b0, run_i = 1'b0;
  interp_mode_e interp_mode_i = interpolate_by_three;
  logic global_scale_we_i = 1'b0, coarse_delay_we_i = 1'b0, amp_table_valid_i = 1'b0, action_valid_i = 1'b0;
  logic [15:0] global_scale_i = '0, amp_table_scale_i = '0, action_scale_i = '0;
  logic [7:0] coarse_delay_i = '0;
  logic clip_clear_i = 1'b0, reject_clear_i = 1'b0, in_valid_i = 1'b0, in_marker_i = 1'b0, stall = 1'b0;
  iq_pair_s in_pair_i = '0;
  iq_pair_s dac_pair_o;
  logic in_ready_o, dac_valid_o, dac_ready_i, clip_status_o, reject_status_o, action_pending_o;
  logic [15:0] amp_mult_o;
  logic [7:0] coarse_delay_o;
  int num_errors = 0, checks_done = 0, nbeats = 0, cycles = 0;
  logic [3:0] res[4] = '{RES_BY_THREE, RES_BY_TWELVE, RES_BY_TWENTY_FOUR, RES_BY_FORTY_EIGHT};
  row_s rows[4] = '{
    '{16'h4000, 16'h8000, 16'h4000, 32'h1234EDCC, 32'h1234EDCC, 1'b0},
    '{16'h6000, 16'h4000, 16'h3000, 32'h4000C000, 32'h3000D000, 1'b0},
    '{16'hB4FE, 16'h8000, 16'hB4FE, 32'h70009000, 32'h7FFF8000, 1'b1},
    '{16'h0000, 16'h8000, 16'h0000, 32'h7FFF8000, 32'h00000000, 1'b0}};

  upconv_scale_ctrl i_dut (.*);
  dac_sink i_sink (.clk_i(clk_i), .valid_i(dac_valid_o), .ready_o(dac_ready_i), .pair_i(dac_pair_o), .stall_i(stall));

  always #5 clk_i = ~clk_i;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bits: global, table, action, delay, clip clear, reject clear
  task automatic pulse(input logic [5:0] p, input logic [15:0] v);
    @(negedge clk_i);
    {global_scale_we_i, amp_table_valid_i, action_valid_i, coarse_delay_we_i, clip_clear_i, reject_clear_i} = p;
    global_scale_i = v;
    amp_table_scale_i = v;
    action_scale_i = v;
    coarse_delay_i = v[7:0];
    @(negedge clk_i);
    {global_scale_we_i, amp_table_valid_i, action_valid_i, coarse_delay_we_i, clip_clear_i, reject_clear_i} = '0;
  endtask

  task automatic beat(input logic [31:0] p, input logic mk);
    @(negedge clk_i);
    in_valid_i = 1'b1;
    in_pair_i = p;
    in_marker_i = mk;
    while (!in_ready_o) @(negedge clk_i);
    @(negedge clk_i);
    in_valid_i = 1'b0;
    nbeats++;
    @(negedge clk_i);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (10) @(negedge clk_i);
    reset_n_i = 1'b1;
    check("reset", {amp_mult_o, coarse_delay_o, clip_status_o, reject_status_o, action_pending_o, in_ready_o, dac_valid_o},
          {RESET_AMP_MULT, RESET_COARSE_DELAY, 5'b00010});
    foreach (rows[n]) begin
      pulse(6'h02, 16'h0000);
      pulse(6'h20, rows[n].g);
      pulse(6'h10, rows[n].t);
      repeat (2) @(negedge clk_i);
      check("amp_mult", amp_mult_o, rows[n].m);
      check("reject", reject_status_o, 1'b0);
      beat(rows[n].p, 1'b0);
      repeat (20) if (i_sink.got.size() == 0) @(negedge clk_i);
      check("pair", i_sink.got.pop_front(), rows[n].o);
      check("clip", clip_status_o, rows[n].c);
    end
    pulse(6'h20, 16'hB4FF);
    repeat (2) @(negedge clk_i);
    check("refused global", {reject_status_o, amp_mult_o}, 17'h10000);
    pulse(6'h03, 16'h0000);
    pulse(6'h10, 16'h8000);
    check("table one", {reject_status_o, clip_status_o}, 2'b00);
    pulse(6'h10, 16'h8001);
    check("refused table", reject_status_o, 1'b1);
    pulse(6'h20, 16'h4000);
    foreach (res[k]) begin
      interp_mode_i = interp_mode_e'(k);
      while (nbeats % res[k] != 0) beat('0, 1'b0);
      pulse(6'h08, 16'h4000 >> k);
      beat('0, 1'b0);
      check("pending", action_pending_o, 1'b1);
      repeat (MIN_CFG_SEGMENT_PAIRS) beat('0, 1'b0);
      beat('0, 1'b1);
      check("pending", action_pending_o, res[k] > 1);
      while (nbeats % res[k] != 0) beat('0, 1'b0);
      beat('0, 1'b0);
      repeat (2) @(negedge clk_i);
      check("applied", {action_pending_o, amp_mult_o}, {1'b0, 16'h2000 >> k});
    end
    pulse(6'h04, 16'h0055);
    check("direct delay", coarse_delay_o, 8'h55);
    digital_upconversion_mode_i = 1'b1;
    pulse(6'h04, 16'h00AA);
    check("held delay", coarse_delay_o, 8'h55);
    run_i = 1'b1;
    @(negedge clk_i);
    check("restart delay", coarse_delay_o, 8'hAA);
    i_sink.got.delete();
    stall = 1'b1;
    repeat (FIFO_DEPTH) beat(32'h11112222, 1'b0);
    check("full", in_ready_o, 1'b0);
    stall = 1'b0;
    repeat (10) @(negedge clk_i);
    check("drained", {dac_valid_o, 8'(i_sink.got.size())}, {1'b0, 8'(FIFO_DEPTH)});
    print_verdict();
  end
endmodule
